// ---- rtl/abrc_access_latch.sv ----
// latches the interface and burst settings at the start of each access
// assumes acc_start_i and acc_end_i come from logic on the same clock
`default_nettype none
`include "abrc_cfg.svh"
module abrc_access_latch (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               acc_start_i,
    input  wire logic               acc_end_i,
    input  wire abrc_pkg::abrc_iface_t iface_i,
    input  wire logic [2:0]         cyc_code_i,
    input  wire logic [1:0]         words_code_i,
    output abrc_pkg::abrc_iface_t   iface_o,
    output logic [3:0]              burst_cycles_o,
    output logic [5:0]              max_words_o,
    output logic                    busy_o
);
    import abrc_pkg::*;

    abrc_state_t  state_reg;
    abrc_state_t  state_next;
    logic [5:0]   words_dec;
    logic         take;

    // settings sampled only when idle, so an access in flight keeps its own
    assign take = (state_reg == ABRC_ST_IDLE) && acc_start_i;

    always_comb begin
        unique case (words_code_i)
            2'b00: words_dec = `ABRC_WORDS_00;
            2'b01: words_dec = `ABRC_WORDS_01;
            2'b10: words_dec = `ABRC_WORDS_10;
            2'b11: words_dec = `ABRC_WORDS_11;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ABRC_ST_IDLE:   if (acc_start_i && !acc_end_i) begin
                state_next = ABRC_ST_ACTIVE;
            end
            ABRC_ST_ACTIVE: if (acc_end_i) begin
                state_next = ABRC_ST_IDLE;
            end
            default:        state_next = ABRC_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg      <= ABRC_ST_IDLE;
            iface_o        <= ABRC_IF_BASIC;
            burst_cycles_o <= 4'h1;
            max_words_o    <= `ABRC_WORDS_00;
        end else begin
            state_reg <= state_next;
            if (take) begin
                iface_o        <= iface_i;
                burst_cycles_o <= {1'b0, cyc_code_i} + 4'h1;
                max_words_o    <= words_dec;
            end
        end
    end

    assign busy_o = (state_reg == ABRC_ST_ACTIVE);
endmodule
`default_nettype wire

// ---- rtl/abrc_cfg.svh ----
// constants for the area 1 burst rom configuration block
// assumes a 32-bit classic wishbone slave with word-aligned registers
`ifndef ABRC_CFG_SVH
`define ABRC_CFG_SVH

// register byte addresses
`define ABRC_ADDR_BURST_CTRL   8'h00
`define ABRC_ADDR_SRAM_CTRL    8'h04
`define ABRC_ADDR_STATUS       8'h08

// burst_rom_area_control field positions (16-bit register)
`define ABRC_BIT_IFACE_SEL     7
`define ABRC_CYC_LSB           4
`define ABRC_CYC_MSB           6
`define ABRC_WORDS_LSB         0
`define ABRC_WORDS_MSB         1
// writable bits of the burst control register; bits 3,2 read as zero
`define ABRC_CTRL_WMASK        16'h00f3
`define ABRC_CTRL_RESET        16'h0000

// byte_ctrl_sram_control: only the area 1 select bit lives here
`define ABRC_BIT_BCSEL         1
`define ABRC_SRAM_WMASK        16'h0002
`define ABRC_SRAM_RESET        16'h0000

// word limits per burst word number code
`define ABRC_WORDS_00          6'h04
`define ABRC_WORDS_01          6'h08
`define ABRC_WORDS_10          6'h10
`define ABRC_WORDS_11          6'h20

`endif

// ---- rtl/abrc_pkg.sv ----
// types shared by the burst rom configuration block
// assumes nothing beyond the cfg header
`default_nettype none
package abrc_pkg;
    typedef enum logic [1:0] {
        ABRC_IF_BASIC = 2'b00,
        ABRC_IF_BCSRAM = 2'b01,
        ABRC_IF_BURST = 2'b10
    } abrc_iface_t;

    typedef enum logic [1:0] {
        ABRC_ST_IDLE = 2'b00,
        ABRC_ST_ACTIVE = 2'b01
    } abrc_state_t;
endpackage
`default_nettype wire

// ---- rtl/abrc_top.sv ----
// area 1 burst rom configuration: registers and latched access settings
// assumes a classic wishbone master on clk_i and an access sequencer
// that pulses acc_start_i / acc_end_i around each external area 1 access
//
// The address map and the Wishbone interface to the registers are this design's own decisions.
`default_nettype none
`include "abrc_cfg.svh"
module abrc_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic        acc_start_i,
    input  wire logic        acc_end_i,
    output logic             burst_mode_o,
    output logic             byte_ctrl_mode_o,
    output logic [3:0]       burst_cycles_o,
    output logic [5:0]       max_words_o,
    output logic             access_busy_o
);
    import abrc_pkg::*;

    logic [15:0]   burst_ctrl_reg;
    logic [15:0]   sram_ctrl_reg;
    logic          req;
    logic          hit_ctrl;
    logic          hit_sram;
    logic          hit_stat;
    logic          mapped;
    logic          wr_ctrl;
    logic          wr_sram;
    logic [15:0]   lane_mask;
    logic [15:0]   ctrl_wdata;
    logic [15:0]   sram_wdata;
    logic [31:0]   rd_data;
    logic [15:0]   status_word;
    abrc_iface_t   iface_sel;
    abrc_iface_t   iface_lat;
    logic [3:0]    cyc_lat;
    logic [5:0]    words_lat;
    logic          busy_lat;

    // one-cycle answer; the !wb_ack_o term drops ack after each transfer
    assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign hit_ctrl = (wb_adr_i == `ABRC_ADDR_BURST_CTRL);
    assign hit_sram = (wb_adr_i == `ABRC_ADDR_SRAM_CTRL);
    assign hit_stat = (wb_adr_i == `ABRC_ADDR_STATUS);
    assign mapped   = hit_ctrl || hit_sram || hit_stat;
    assign wr_ctrl  = req && wb_we_i && hit_ctrl;
    assign wr_sram  = req && wb_we_i && hit_sram;
    assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // reserved bits stay zero through the write mask
    assign ctrl_wdata = (burst_ctrl_reg & ~(lane_mask & `ABRC_CTRL_WMASK))
                      | (wb_dat_i[15:0] & lane_mask & `ABRC_CTRL_WMASK);
    assign sram_wdata = (sram_ctrl_reg & ~(lane_mask & `ABRC_SRAM_WMASK))
                      | (wb_dat_i[15:0] & lane_mask & `ABRC_SRAM_WMASK);

    // both selects set is a software fault; burst rom wins so the
    // area never drives byte-control strobes into a rom
    assign iface_sel =
        burst_ctrl_reg[`ABRC_BIT_IFACE_SEL] ? ABRC_IF_BURST :
        sram_ctrl_reg[`ABRC_BIT_BCSEL]      ? ABRC_IF_BCSRAM :
                                              ABRC_IF_BASIC;

    assign status_word = {7'h00, busy_lat, iface_lat, words_lat};
    assign rd_data = hit_ctrl ? {16'h0000, burst_ctrl_reg} :
                     hit_sram ? {16'h0000, sram_ctrl_reg} :
                     hit_stat ? {16'h0000, status_word} :
                                32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            burst_ctrl_reg <= `ABRC_CTRL_RESET;
            sram_ctrl_reg  <= `ABRC_SRAM_RESET;
        end else begin
            if (wr_ctrl) begin
                burst_ctrl_reg <= ctrl_wdata;
            end
            if (wr_sram) begin
                sram_ctrl_reg <= sram_wdata;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req && mapped;
            wb_err_o <= req && !mapped;
            wb_dat_o <= (req && !wb_we_i) ? rd_data : 32'h0000_0000;
        end
    end

    abrc_access_latch u_latch (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .acc_start_i    (acc_start_i),
        .acc_end_i      (acc_end_i),
        .iface_i        (iface_sel),
        .cyc_code_i     (burst_ctrl_reg[`ABRC_CYC_MSB:`ABRC_CYC_LSB]),
        .words_code_i   (burst_ctrl_reg[`ABRC_WORDS_MSB:`ABRC_WORDS_LSB]),
        .iface_o        (iface_lat),
        .burst_cycles_o (cyc_lat),
        .max_words_o    (words_lat),
        .busy_o         (busy_lat)
    );

    // outputs follow latched flops directly
    assign burst_mode_o     = (iface_lat == ABRC_IF_BURST);
    assign byte_ctrl_mode_o = (iface_lat == ABRC_IF_BCSRAM);
    assign burst_cycles_o   = cyc_lat;
    assign max_words_o      = words_lat;
    assign access_busy_o    = busy_lat;
endmodule
`default_nettype wire

// ---- tb/abrc_assertions.sv ----
// port checker for the area 1 burst rom config block
// assumes one clock domain; bound onto abrc_top
`default_nettype none
module abrc_assertions (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic       wb_ack_o,
    input wire logic       wb_err_o,
    input wire logic       acc_start_i,
    input wire logic       acc_end_i,
    input wire logic [3:0] burst_cycles_o,
    input wire logic [5:0] max_words_o,
    input wire logic       access_busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic map_w = wb_adr_i inside {8'h00, 8'h04, 8'h08};
    sequence take_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    reg_ack_a: assert property (take_s ##0 map_w |=> wb_ack_o)
        else $error("no ack");
    unmapped_err_a: assert property (take_s ##0 !map_w |=> wb_err_o)
        else $error("no err");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("long ack");
    cycle_range_a: assert property (burst_cycles_o inside {[1:8]})
        else $error("bad cycles");
    word_set_a: assert property (max_words_o inside {4, 8, 16, 32})
        else $error("bad words");
    busy_rise_a: assert property (acc_start_i && !access_busy_o &&
        !acc_end_i |=> access_busy_o) else $error("no busy");
    busy_fall_a: assert property (access_busy_o && acc_end_i
        |=> !access_busy_o) else $error("busy stuck");
    latch_hold_a: assert property (access_busy_o |=>
        $stable(burst_cycles_o) && $stable(max_words_o))
        else $error("changed in access");
endmodule
bind abrc_top abrc_assertions u_abrc_assertions (.*);
`default_nettype wire

// ---- tb/abrc_seq_model.sv ----
// access sequencer stand-in: frames one area 1 access per go pulse
// assumes go_i comes only while no access runs
`default_nettype none
module abrc_seq_model (
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic [3:0] len_i,
    output logic            acc_start_o = 1'b0,
    output logic            acc_end_o = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt_reg = 4'h0;
    // end follows start by len_i cycles, so slow accesses come from len_i
    always @(posedge clk_i) begin
        acc_start_o <= go_i;
        acc_end_o <= cnt_reg == 4'h1;
        cnt_reg <= go_i ? len_i : cnt_reg - 4'(cnt_reg != 4'h0);
    end
endmodule
`default_nettype wire

// ---- tb/abrc_top_tb.sv ----
// self-checking bench for the area 1 burst rom config block
// assumes answers within a few cycles of each request
`default_nettype none
module abrc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_i = 0, rst_i = 1, req = 0, we = 0, go = 0;
    logic [7:0]  adr = 0;
    logic [3:0]  sel = 0, len = 1, cyc_o;
    logic [31:0] wdat = 0, rdat, rv;
    logic [5:0]  mw;
    logic        ack, err, ef, st, fin, bm, bcm, busy;
    int          err_count = 0, checks = 0, ctrl = 0, d;
    always #12.5 clk_i = ~clk_i;
    abrc_top u_abrc_top (.clk_i, .rst_i, .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .acc_start_i(st), .acc_end_i(fin), .burst_mode_o(bm),
        .byte_ctrl_mode_o(bcm), .burst_cycles_o(cyc_o),
        .max_words_o(mw), .access_busy_o(busy));
    abrc_seq_model u_abrc_seq_model (.clk_i, .go_i(go), .len_i(len),
        .acc_start_o(st), .acc_end_o(fin));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        if (err_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // values read just after an edge are those sampled at that edge
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] v, input logic [3:0] s);
        @(posedge clk_i);
        req <= 1;
        we <= w;
        adr <= a;
        wdat <= v;
        sel <= s;
        // the wait ends on ack or err; only the watchdog ends it if neither comes
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1 && err !== 1'b1);
        ef = err;
        rv = rdat;
        req <= 0;
        we <= 0;
    endtask
    task automatic access(input logic [3:0] l);
        @(posedge clk_i);
        go <= 1;
        len <= l;
        @(posedge clk_i);
        go <= 0;
        repeat (3) @(posedge clk_i);
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        give_verdict;
    end
    initial begin
        d = $urandom(32'h6f2f);
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        chk(cyc_o, 1);
        chk(mw, 4);
        wb(0, 8'h00, 0, 4'hf);
        chk(rv, 0);
        for (int i = 0; i < 12; i++) begin
            d = $urandom;
            wb(1, 8'h04, 0, 4'hf);
            wb(1, 8'h00, d, d[31:28]);
            if (d[28]) ctrl = d & 32'hf3;
            wb(0, 8'h00, 0, 4'hf);
            chk(rv, ctrl);
            access(4'h9);
            chk(cyc_o, ctrl[6:4] + 1);
            chk(mw, 4 << ctrl[1:0]);
            chk(bm, ctrl[7]);
            wb(1, 8'h00, ~d, 4'hf);
            chk(cyc_o, ctrl[6:4] + 1);
            ctrl = ~d & 32'hf3;
            repeat (10) @(posedge clk_i);
        end
        wb(1, 8'h00, 0, 4'h1);
        wb(1, 8'h04, 32'h3, 4'h1);
        access(4'h1);
        chk(bcm, 1);
        chk(bm, 0);
        wb(0, 8'h08, 0, 4'hf);
        chk(rv, 32'h0000_0044);
        wb(0, 8'h0c, 0, 4'hf);
        chk(ef, 1);
        give_verdict;
    end
endmodule
`default_nettype wire
